// ### inc/sdp_pkg.sv
// constants, field layout and state codes of the serializer emphasis, dither and pll register bank
// assumes an apb master with 32-bit data; the register bytes sit in the low lane
package sdp_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int IDX_W  = 14;
    localparam int LANES  = 2;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_LANE0  = 14'h05C4;
    localparam logic [IDX_W-1:0] IDX_LANE1  = 14'h05C6;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h05C7;
    localparam logic [IDX_W-1:0] IDX_DITHER = 14'h0922;
    localparam logic [IDX_W-1:0] IDX_PLL    = 14'h1222;
    localparam logic [1:0]       ALIGN_OK   = 2'h0;

    // ****************************************
    // emphasis register fields
    // ****************************************
    localparam int POST_POL_BIT = 7;
    localparam int POST_LVL_MSB = 6;
    localparam int POST_LVL_LSB = 4;
    localparam int PRE_POL_BIT  = 3;
    localparam int PRE_LVL_MSB  = 2;
    localparam int PRE_LVL_LSB  = 0;
    localparam int LVL_W        = 3;
    localparam logic [LVL_W-1:0] LVL_MAX_CODE = 3'h4;
    localparam logic [REG_W-1:0] EMPH_RESET   = 8'h00;

    // ****************************************
    // whole-byte control values
    // ****************************************
    localparam logic [REG_W-1:0] DITHER_ON  = 8'h70;
    localparam logic [REG_W-1:0] DITHER_OFF = 8'h71;
    localparam logic [REG_W-1:0] PLL_IDLE   = 8'h00;
    localparam logic [REG_W-1:0] PLL_CAL    = 8'h04;

    // ****************************************
    // status register bits
    // ****************************************
    localparam int ST_DITHER_BIT = 0;
    localparam int ST_PLL_BIT    = 1;
    localparam int ST_POST_BAD   = 2;
    localparam int ST_PRE_BAD    = 4;

    typedef enum logic [1:0] {
        SDP_ST_IDLE   = 2'b01,
        SDP_ST_ANSWER = 2'b10
    } sdp_apb_state_type;

endpackage

// ### design/sdp_apb_port.sv
// apb slave handshake: one wait state, registered answer
// assumes the master holds its request until pready is seen high
`timescale 1ns/1ps
module sdp_apb_port #(
    parameter int DATA_W = 32
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              hit,
    input  wire logic [DATA_W-1:0] rd_value,
    output logic                   pready,
    output logic                   pslverr,
    output logic [DATA_W-1:0]      prdata,
    output logic                   commit
);

    sdp_pkg::sdp_apb_state_type state;
    sdp_pkg::sdp_apb_state_type next_state;
    logic                       next_pready;
    logic                       next_pslverr;
    logic [DATA_W-1:0]          next_prdata;

    always_comb begin
        next_state   = state;
        next_pready  = 1'b0;
        next_pslverr = pslverr;
        next_prdata  = prdata;
        unique case (state)
            sdp_pkg::SDP_ST_IDLE: begin
                if (psel && penable) begin
                    next_state   = sdp_pkg::SDP_ST_ANSWER;
                    next_pready  = 1'b1;
                    next_pslverr = !hit;
                    next_prdata  = hit ? rd_value : '0;
                end
            end
            sdp_pkg::SDP_ST_ANSWER: begin
                next_state   = sdp_pkg::SDP_ST_IDLE;
                next_pslverr = 1'b0;
                next_prdata  = '0;
            end
            default: begin
                next_state = sdp_pkg::SDP_ST_IDLE;
            end
        endcase
    end

    // writes land on the very edge that samples pready high
    assign commit = pready && psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= sdp_pkg::SDP_ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            state   <= next_state;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

endmodule

// ### design/sdp_lane_emph.sv
// one lane's emphasis register with decoded tap fields and invalid-code flags
// assumes wr is a single-cycle commit strobe from the bus slave
`timescale 1ns/1ps
module sdp_lane_emph #(
    parameter int REG_W = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             wr,
    input  wire logic [REG_W-1:0] wdata,
    output logic [REG_W-1:0]      value,
    output logic                  post_bad,
    output logic                  pre_bad
);

    logic [REG_W-1:0] next_value;
    logic             next_post_bad;
    logic             next_pre_bad;

    always_comb begin
        next_value    = wr ? wdata : value;
        // invalid codes are stored as written; the flags let software see them
        next_post_bad = next_value[sdp_pkg::POST_LVL_MSB:sdp_pkg::POST_LVL_LSB] > sdp_pkg::LVL_MAX_CODE;
        next_pre_bad  = next_value[sdp_pkg::PRE_LVL_MSB:sdp_pkg::PRE_LVL_LSB] > sdp_pkg::LVL_MAX_CODE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value    <= sdp_pkg::EMPH_RESET;
            post_bad <= 1'b0;
            pre_bad  <= 1'b0;
        end else begin
            value    <= next_value;
            post_bad <= next_post_bad;
            pre_bad  <= next_pre_bad;
        end
    end

endmodule

// ### design/sdp_regs.sv
// serializer emphasis, large dither and pll calibration register bank behind apb
// assumes one clock pclk, asynchronous active-low presetn, analog loads outside
//
// Contract
// - post-tap level in bits 6:4, codes 0-4 give 0-12 dB, 5-7 invalid.
// - pre-tap level in bits 2:0, codes 0-4 give 0-12 dB, 5-7 invalid.
// - bit 3 pre-tap, bit 7 post-tap polarity, 1 inverts; emphasis resets zero.
// - dither byte resets to enable; 0x70 enables, 0x71 disables large dither.
`timescale 1ns/1ps
module sdp_regs #(
    parameter int ADDR_W = sdp_pkg::ADDR_W,
    parameter int DATA_W = sdp_pkg::DATA_W,
    parameter int LANES  = sdp_pkg::LANES
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ADDR_W-1:0]             paddr,
    input  wire logic [DATA_W-1:0]             pwdata,
    input  wire logic [DATA_W/8-1:0]           pstrb,
    output logic [DATA_W-1:0]                  prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [LANES*sdp_pkg::LVL_W-1:0]    post_level,
    output logic [LANES-1:0]                   post_invert,
    output logic [LANES*sdp_pkg::LVL_W-1:0]    pre_level,
    output logic [LANES-1:0]                   pre_invert,
    output logic                               dither_enable,
    output logic                               pll_cal_request
);

    localparam int RW = sdp_pkg::REG_W;
    localparam int LW = sdp_pkg::LVL_W;

    // ****************************************
    // address decode
    // ****************************************
    logic [sdp_pkg::IDX_W-1:0] idx;
    logic                      aligned;
    logic [LANES-1:0]          hit_lane;
    logic                      hit_status;
    logic                      hit_dither;
    logic                      hit_pll;
    logic                      hit;
    logic                      commit;
    logic                      wr_ok;
    logic [RW-1:0]             wbyte;

    assign idx        = paddr[sdp_pkg::IDX_W+1:2];
    assign aligned    = paddr[1:0] == sdp_pkg::ALIGN_OK;
    assign hit_lane[0] = aligned && idx == sdp_pkg::IDX_LANE0;
    assign hit_lane[1] = aligned && idx == sdp_pkg::IDX_LANE1;
    assign hit_status = aligned && idx == sdp_pkg::IDX_STATUS;
    assign hit_dither = aligned && idx == sdp_pkg::IDX_DITHER;
    assign hit_pll    = aligned && idx == sdp_pkg::IDX_PLL;
    assign hit        = |hit_lane || hit_status || hit_dither || hit_pll;
    // the low byte lane carries every register; other strobes are ignored
    assign wr_ok      = commit && pwrite && pstrb[0];
    assign wbyte      = pwdata[RW-1:0];

    // ****************************************
    // emphasis lanes
    // ****************************************
    logic [RW-1:0]    lane_value [LANES];
    logic [LANES-1:0] lane_post_bad;
    logic [LANES-1:0] lane_pre_bad;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            sdp_lane_emph #(
                .REG_W (RW)
            ) u_lane (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr       (wr_ok && hit_lane[g]),
                .wdata    (wbyte),
                .value    (lane_value[g]),
                .post_bad (lane_post_bad[g]),
                .pre_bad  (lane_pre_bad[g])
            );
            assign post_level[g*LW +: LW] = lane_value[g][sdp_pkg::POST_LVL_MSB:sdp_pkg::POST_LVL_LSB];
            assign pre_level[g*LW +: LW]  = lane_value[g][sdp_pkg::PRE_LVL_MSB:sdp_pkg::PRE_LVL_LSB];
            assign post_invert[g]         = lane_value[g][sdp_pkg::POST_POL_BIT];
            assign pre_invert[g]          = lane_value[g][sdp_pkg::PRE_POL_BIT];
        end
    endgenerate

    // ****************************************
    // dither and pll control bytes
    // ****************************************
    logic [RW-1:0] dither_byte;
    logic [RW-1:0] pll_byte;
    logic [RW-1:0] next_dither_byte;
    logic [RW-1:0] next_pll_byte;
    logic          next_dither_enable;
    logic          next_pll_cal_request;

    always_comb begin
        next_dither_byte     = dither_byte;
        next_dither_enable   = dither_enable;
        next_pll_byte        = pll_byte;
        if (wr_ok && hit_dither) begin
            next_dither_byte = wbyte;
            // other codes are kept as written but leave the dither state alone
            if (wbyte == sdp_pkg::DITHER_ON) begin
                next_dither_enable = 1'b1;
            end else if (wbyte == sdp_pkg::DITHER_OFF) begin
                next_dither_enable = 1'b0;
            end
        end
        if (wr_ok && hit_pll) begin
            next_pll_byte = wbyte;
        end
        // request stands while the byte holds the calibrate code
        next_pll_cal_request = next_pll_byte == sdp_pkg::PLL_CAL;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dither_byte     <= sdp_pkg::DITHER_ON;
            dither_enable   <= 1'b1;
            pll_byte        <= sdp_pkg::PLL_IDLE;
            pll_cal_request <= 1'b0;
        end else begin
            dither_byte     <= next_dither_byte;
            dither_enable   <= next_dither_enable;
            pll_byte        <= next_pll_byte;
            pll_cal_request <= next_pll_cal_request;
        end
    end

    // ****************************************
    // read back
    // ****************************************
    logic [RW-1:0]     status;
    logic [DATA_W-1:0] rd_value;

    always_comb begin
        status                                  = '0;
        status[sdp_pkg::ST_DITHER_BIT]          = dither_enable;
        status[sdp_pkg::ST_PLL_BIT]             = pll_cal_request;
        status[sdp_pkg::ST_POST_BAD +: LANES]   = lane_post_bad;
        status[sdp_pkg::ST_PRE_BAD +: LANES]    = lane_pre_bad;
        rd_value                                = '0;
        if (hit_lane[0]) begin
            rd_value[RW-1:0] = lane_value[0];
        end else if (hit_lane[1]) begin
            rd_value[RW-1:0] = lane_value[1];
        end else if (hit_status) begin
            rd_value[RW-1:0] = status;
        end else if (hit_dither) begin
            rd_value[RW-1:0] = dither_byte;
        end else if (hit_pll) begin
            rd_value[RW-1:0] = pll_byte;
        end
    end

    sdp_apb_port #(
        .DATA_W (DATA_W)
    ) u_port (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .hit      (hit),
        .rd_value (rd_value),
        .pready   (pready),
        .pslverr  (pslverr),
        .prdata   (prdata),
        .commit   (commit)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_post_write: assert property (
        (wr_ok && hit_lane[1]) |=> post_level[LW +: LW] == $past(pwdata[6:4])
    ) else $error("lane 1 post level not taken from write");

    chk_post_flag: assert property (
        lane_post_bad[1] == (post_level[LW +: LW] > 3'h4)
    ) else $error("lane 1 post invalid flag wrong");

    chk_pre_write: assert property (
        (wr_ok && hit_lane[0]) |=> pre_level[LW-1:0] == $past(pwdata[2:0])
    ) else $error("lane 0 pre level not taken from write");

    chk_pre_flag: assert property (
        lane_pre_bad[0] == (pre_level[LW-1:0] > 3'h4)
    ) else $error("lane 0 pre invalid flag wrong");

    chk_polarity_bits: assert property (
        (wr_ok && hit_lane[1]) |=> post_invert[1] == $past(pwdata[7]) && pre_invert[1] == $past(pwdata[3])
    ) else $error("lane 1 polarity bits wrong");

    chk_dither_on: assert property (
        (wr_ok && hit_dither && wbyte == 8'h70) |=> dither_enable && dither_byte == 8'h70
    ) else $error("dither not enabled by enable code");

    chk_dither_off: assert property (
        (wr_ok && hit_dither && wbyte == 8'h71) |=> !dither_enable ##1 !dither_enable || $past(wr_ok)
    ) else $error("dither not disabled by disable code");

    chk_pll_request: assert property (
        (wr_ok && hit_pll) |=> pll_cal_request == ($past(wbyte) == 8'h04)
    ) else $error("pll request does not follow byte");

    chk_apb_answer: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready
    ) else $error("apb answer not one wait state");

    chk_unmapped_err: assert property (
        (psel && penable && !pready && !hit) |=> pslverr && prdata == '0
    ) else $error("unmapped access not refused");

    chk_post_write0: assert property (
        (wr_ok && hit_lane[0]) |=> post_level[LW-1:0] == $past(pwdata[6:4])
    ) else $error("lane 0 post level not taken from write");

    chk_post_flag0: assert property (
        lane_post_bad[0] == (post_level[LW-1:0] > 3'h4)
    ) else $error("lane 0 post invalid flag wrong");

    chk_pre_write1: assert property (
        (wr_ok && hit_lane[1]) |=> pre_level[LW +: LW] == $past(pwdata[2:0])
    ) else $error("lane 1 pre level not taken from write");

    chk_pre_flag1: assert property (
        lane_pre_bad[1] == (pre_level[LW +: LW] > 3'h4)
    ) else $error("lane 1 pre invalid flag wrong");

    chk_polarity_lane0: assert property (
        (wr_ok && hit_lane[0]) |=> post_invert[0] == $past(pwdata[7]) && pre_invert[0] == $past(pwdata[3])
    ) else $error("lane 0 polarity bits wrong");

    chk_lane_hold: assert property (
        !(wr_ok && |hit_lane) |=> $stable(post_level) && $stable(pre_level)
            && $stable(post_invert) && $stable(pre_invert)
    ) else $error("lane fields changed without a write");

    chk_read_lane0: assert property (
        (psel && penable && !pready && hit_lane[0]) |=> prdata[RW-1:0] == lane_value[0]
    ) else $error("lane 0 read data wrong");

    chk_read_lane1: assert property (
        (psel && penable && !pready && hit_lane[1]) |=> prdata[RW-1:0] == lane_value[1]
    ) else $error("lane 1 read data wrong");

    chk_dither_store: assert property (
        (wr_ok && hit_dither) |=> dither_byte == $past(wbyte)
    ) else $error("dither byte not stored as written");

    chk_dither_keep: assert property (
        (wr_ok && hit_dither && wbyte != 8'h70 && wbyte != 8'h71) |=> $stable(dither_enable)
    ) else $error("dither state moved by a foreign code");

    chk_dither_hold: assert property (
        !(wr_ok && hit_dither) |=> $stable(dither_enable) && $stable(dither_byte)
    ) else $error("dither changed without a write");

    chk_read_dither: assert property (
        (psel && penable && !pready && hit_dither) |=> prdata[RW-1:0] == dither_byte
    ) else $error("dither read data wrong");

    chk_pll_level: assert property (
        pll_cal_request == (pll_byte == 8'h04)
    ) else $error("pll request not matching byte");

    chk_pll_hold: assert property (
        !(wr_ok && hit_pll) |=> $stable(pll_cal_request) && $stable(pll_byte)
    ) else $error("pll byte changed without a write");

    chk_read_pll: assert property (
        (psel && penable && !pready && hit_pll) |=> prdata[RW-1:0] == pll_byte
    ) else $error("pll read data wrong");

    chk_strobe_gate: assert property (
        (commit && pwrite && !pstrb[0]) |=> $stable(dither_byte) && $stable(pll_byte)
            && $stable(post_level) && $stable(pre_level)
    ) else $error("write without low strobe took effect");

    chk_err_refused: assert property (
        (commit && !hit) |=> $stable(dither_byte) && $stable(pll_byte)
    ) else $error("refused write took effect");

    chk_err_ready: assert property (
        pslverr |-> pready
    ) else $error("error shown outside answer cycle");

    chk_data_idle: assert property (
        !pready |-> prdata == '0
    ) else $error("read data shown outside answer cycle");

    chk_ready_pulse: assert property (
        pready |=> !pready
    ) else $error("ready held longer than one cycle");

    chk_setup_wait: assert property (
        (psel && !penable) |=> !pready
    ) else $error("ready raised after setup cycle");

endmodule

// ### verif/sdp_regs_tb_top.sv
// self-checking bench for the emphasis, dither and pll register bank
// assumes the apb slave answers after one wait state and holds no other clock
`timescale 1ns/1ps
module sdp_regs_tb_top;

    // ****************************************
    // signals and instance
    // ****************************************
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  post_level;
    logic [1:0]  post_invert;
    logic [5:0]  pre_level;
    logic [1:0]  pre_invert;
    logic        dither_enable;
    logic        pll_cal_request;
    int          bad_count;
    int          comparisons;
    int          cycles;
    logic [31:0] rd;
    logic        err;

    localparam logic [15:0] A_LANE0  = 16'h1710;
    localparam logic [15:0] A_LANE1  = 16'h1718;
    localparam logic [15:0] A_STATUS = 16'h171C;
    localparam logic [15:0] A_DITHER = 16'h2488;
    localparam logic [15:0] A_PLL    = 16'h4888;

    sdp_regs u_sdp_regs (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .pstrb           (pstrb),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .post_level      (post_level),
        .post_invert     (post_invert),
        .pre_level       (pre_level),
        .pre_invert      (pre_invert),
        .dither_enable   (dither_enable),
        .pll_cal_request (pll_cal_request)
    );

    // ****************************************
    // clock, watchdog, shared tasks
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // whole run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (act !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // request held until pready is sampled high; released at that edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
    endtask

    // write, then let the commit edge land before outputs are judged
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
        apb(1'b1, a, {24'h000000, d}, s);
        @(posedge pclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        check({31'h00000000, dither_enable}, 32'h00000001);
        check({31'h00000000, pll_cal_request}, 32'h00000000);
        check({20'h00000, post_level, pre_level}, 32'h00000000);
        check({28'h0000000, post_invert, pre_invert}, 32'h00000000);
        apb(1'b0, A_LANE0, 32'h00000000, 4'h0);
        check(rd, 32'h00000000);
        apb(1'b0, A_LANE1, 32'h00000000, 4'h0);
        check(rd, 32'h00000000);
        apb(1'b0, A_DITHER, 32'h00000000, 4'h0);
        check(rd, 32'h00000070);
        apb(1'b0, A_PLL, 32'h00000000, 4'h0);
        check(rd, 32'h00000000);
    endtask

    // every tap code on lane 0, both polarities, invalid codes flagged
    task automatic t_lane_codes();
        logic [2:0] c;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            v = {c[0], c, ~c[0], 3'h7 - c};
            wr(A_LANE0, v, 4'h1);
            check({29'h00000000, post_level[2:0]}, {29'h00000000, c});
            check({29'h00000000, pre_level[2:0]}, {29'h00000000, 3'h7 - c});
            check({30'h00000000, post_invert[0], pre_invert[0]}, {30'h00000000, c[0], ~c[0]});
            check({26'h0000000, post_level[5:3], pre_level[5:3]}, 32'h00000000);
            apb(1'b0, A_LANE0, 32'h00000000, 4'h0);
            check(rd, {24'h000000, v});
            apb(1'b0, A_STATUS, 32'h00000000, 4'h0);
            check({30'h00000000, rd[4], rd[2]}, {30'h00000000, (3'h7 - c) > 3'h4, c > 3'h4});
        end
    endtask

    task automatic t_lane1();
        wr(A_LANE1, 8'hF3, 4'h1);
        check({26'h0000000, post_level[5:3], pre_level[5:3]}, 32'h0000003B);
        check({30'h00000000, post_invert[1], pre_invert[1]}, 32'h00000002);
        apb(1'b0, A_LANE0, 32'h00000000, 4'h0);
        check(rd, 32'h000000F0);
        apb(1'b0, A_STATUS, 32'h00000000, 4'h0);
        check(rd, 32'h0000000D);
        wr(A_LANE1, 8'h0C, 4'h0);
        apb(1'b0, A_LANE1, 32'h00000000, 4'h0);
        check(rd, 32'h000000F3);
    endtask

    task automatic t_dither();
        wr(A_DITHER, 8'h71, 4'h1);
        check({31'h00000000, dither_enable}, 32'h00000000);
        wr(A_DITHER, 8'h55, 4'h1);
        check({31'h00000000, dither_enable}, 32'h00000000);
        wr(A_DITHER, 8'h70, 4'h1);
        check({31'h00000000, dither_enable}, 32'h00000001);
        wr(A_DITHER, 8'h71, 4'h0);
        check({31'h00000000, dither_enable}, 32'h00000001);
        apb(1'b0, A_DITHER, 32'h00000000, 4'h0);
        check(rd, 32'h00000070);
    endtask

    task automatic t_pll();
        wr(A_PLL, 8'h04, 4'h1);
        check({31'h00000000, pll_cal_request}, 32'h00000001);
        apb(1'b0, A_PLL, 32'h00000000, 4'h0);
        check(rd, 32'h00000004);
        apb(1'b0, A_STATUS, 32'h00000000, 4'h0);
        check(rd, 32'h0000000F);
        wr(A_PLL, 8'h00, 4'h1);
        check({31'h00000000, pll_cal_request}, 32'h00000000);
    endtask

    // unmapped and misaligned places answer with an error and no data
    task automatic t_errors();
        apb(1'b0, 16'h0004, 32'h00000000, 4'h0);
        check({31'h00000000, err}, 32'h00000001);
        check(rd, 32'h00000000);
        apb(1'b1, 16'h2489, 32'h00000071, 4'h1);
        check({31'h00000000, err}, 32'h00000001);
        apb(1'b1, A_STATUS, 32'h000000FF, 4'h1);
        check({31'h00000000, err}, 32'h00000000);
        @(posedge pclk);
        check({31'h00000000, dither_enable}, 32'h00000001);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 16'h0000;
        pwdata      = 32'h00000000;
        pstrb       = 4'h0;
        bad_count   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_lane_codes();
        t_lane1();
        t_dither();
        t_pll();
        t_errors();
        close_out();
    end

endmodule
